/* core/spi_clock_config.sv */
// serial interface clock timing, configuration and multi-master take-over logic
`timescale 1ns/1ps
// ==========================================================================
// How it works
// - phase bit picks which serial clock edge latches data.
// - polarity bit picks active-high or active-low clock; four modes.
// - master and slave must share phase and polarity.
// - rate register sets master serial clock frequency.
// - slave mode ignores rate register, follows external clock.
// - frame-size field sets one to eight bits per master transfer.
// - select low while master sets mode fault, clears enables.
// - master serial clock at most half the system clock.
module spi_clock_config (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic [1:0] reg_sel_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_n_o,
    input wire logic slave_select_n_i,
    output logic mosi_o,
    input wire logic miso_i,
    output logic sample_o,
    output logic shift_o,
    output logic busy_o
);
    import spi_cfg_pkg::*;

    typedef enum logic [1:0] {IDLE = 2'b00, LEAD = 2'b01, TRAIL = 2'b11} state_t;

    // ======================================================================
    // reset release and input synchronisers
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) rst_sync <= 2'b00;
        else rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    logic [1:0] sck_s;
    logic [1:0] nss_s;
    logic [1:0] miso_s;
    logic sck_d;
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sck_s <= 2'b00;
            nss_s <= 2'b11;
            miso_s <= 2'b00;
            sck_d <= 1'b0;
        end else begin
            sck_s <= {sck_s[0], sclk_i};
            nss_s <= {nss_s[0], slave_select_n_i};
            miso_s <= {miso_s[0], miso_i};
            sck_d <= sck_s[1];
        end
    end

    // ======================================================================
    // registers
    logic [7:0] config_reg;
    logic [7:0] clock_rate_register;
    logic [7:0] data_register;
    logic interface_enable_bit;
    logic master_enable_bit;
    logic mode_fault_flag;
    logic clock_phase_bit;
    logic clock_polarity_bit;
    logic [2:0] frame_size_field;
    logic [2:0] bit_count_field;
    logic slave_selected_flag;
    logic is_master;
    logic fault;
    logic wr_ctl;
    logic wr_cfg;
    logic wr_ckr;
    logic wr_dat;
    logic start;
    state_t state;
    state_t next_state;
    logic [7:0] div_cnt;
    logic [3:0] bits_done;
    logic [3:0] frame_bits;
    logic tick;
    logic sclk_q;
    logic [7:0] shreg;
    logic rx_bit;
    logic rx_next;
    logic hold_first;

    assign clock_phase_bit = config_reg[CFG_PHASE_BIT];
    assign clock_polarity_bit = config_reg[CFG_POL_BIT];
    assign frame_size_field = config_reg[CFG_FRS_HI:CFG_FRS_LO];
    assign bit_count_field = bits_done[2:0];
    assign slave_selected_flag = ~nss_s[1];
    assign is_master = interface_enable_bit & master_enable_bit;
    assign fault = is_master & ~nss_s[1];
    assign wr_ctl = reg_wr_i & (reg_sel_i == SEL_CTL);
    assign wr_cfg = reg_wr_i & (reg_sel_i == SEL_CFG);
    assign wr_ckr = reg_wr_i & (reg_sel_i == SEL_CKR);
    assign wr_dat = reg_wr_i & (reg_sel_i == SEL_DAT);
    // frame size 0 means eight bits
    assign frame_bits = (frame_size_field == 3'h0) ? BITS_MAX : {1'b0, frame_size_field};
    assign start = wr_dat & is_master & (state == IDLE) & ~fault;
    assign busy_o = (state != IDLE);
    // phase 1 shows the msb before the first edge, so that edge must not shift it away
    assign hold_first = clock_phase_bit & (state == LEAD) & (bits_done == 4'h0);
    // in phase 1 the last bit is latched on the very edge that ends the frame
    assign rx_next = clock_phase_bit ? miso_s[1] : rx_bit;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            config_reg <= CFG_RESET;
            clock_rate_register <= CKR_RESET;
            interface_enable_bit <= CTL_RESET[CTL_EN_BIT];
            master_enable_bit <= CTL_RESET[CTL_MST_BIT];
            mode_fault_flag <= CTL_RESET[CTL_MODE_FAULT_FLAG_BIT];
        end else begin
            if (wr_cfg) begin
                config_reg <= (reg_wdata_i & CFG_WRITE_MASK) | {2'b00, bit_count_field, 3'b000};
            end else begin
                config_reg[CFG_BC_HI:CFG_BC_LO] <= bit_count_field;
            end
            if (wr_ckr) clock_rate_register <= reg_wdata_i;
            // hardware fault beats a concurrent software write
            if (fault) begin
                mode_fault_flag <= 1'b1;
                master_enable_bit <= 1'b0;
                interface_enable_bit <= 1'b0;
            end else if (wr_ctl) begin
                mode_fault_flag <= reg_wdata_i[CTL_MODE_FAULT_FLAG_BIT];
                master_enable_bit <= reg_wdata_i[CTL_MST_BIT];
                interface_enable_bit <= reg_wdata_i[CTL_EN_BIT];
            end
        end
    end

    // ======================================================================
    // master clock generator
    // half period of rate+1 cycles: never faster than half system clock
    assign tick = (div_cnt == 8'h00);

    always_comb begin
        next_state = state;
        unique case (state)
            IDLE: if (start) next_state = LEAD;
            LEAD: if (!is_master) next_state = IDLE;
                  else if (tick) next_state = TRAIL;
            TRAIL: if (!is_master) next_state = IDLE;
                   else if (tick && bits_done == frame_bits) next_state = IDLE;
                   else if (tick) next_state = LEAD;
            default: next_state = IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= IDLE;
            div_cnt <= 8'h00;
            bits_done <= 4'h0;
            sclk_q <= 1'b0;
            shreg <= 8'h00;
            rx_bit <= 1'b0;
        end else begin
            state <= next_state;
            if (start || tick) div_cnt <= clock_rate_register;
            else if (state != IDLE) div_cnt <= div_cnt - 8'h01;
            if (start) begin
                bits_done <= 4'h0;
                shreg <= reg_wdata_i;
            end else if (state == LEAD && tick) begin
                bits_done <= bits_done + 4'h1;
            end
            if (state != IDLE && tick && shift_o && !hold_first) begin
                shreg <= {shreg[6:0], rx_bit};
            end
            if (is_master && sample_o) rx_bit <= miso_s[1];
            // idle clock sits at the inactive level of the polarity
            if (next_state == IDLE) sclk_q <= clock_polarity_bit;
            else if (tick && state != IDLE) sclk_q <= ~sclk_q;
        end
    end

    // ======================================================================
    // edge selection
    // a slave reads edges of the external clock; rate register is unused there
    logic sck_rise;
    logic sck_fall;
    logic lead_edge;
    logic trail_edge;
    logic slave_active;
    assign slave_active = interface_enable_bit & ~master_enable_bit & ~nss_s[1];
    assign sck_rise = sck_s[1] & ~sck_d;
    assign sck_fall = ~sck_s[1] & sck_d;
    // leading edge is rise for idle-low clock, fall for idle-high
    assign lead_edge = is_master ? (state == LEAD && tick)
                     : (slave_active & (clock_polarity_bit ? sck_fall : sck_rise));
    assign trail_edge = is_master ? (state == TRAIL && tick)
                      : (slave_active & (clock_polarity_bit ? sck_rise : sck_fall));
    assign sample_o = clock_phase_bit ? trail_edge : lead_edge;
    assign shift_o = clock_phase_bit ? lead_edge : trail_edge;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sclk_o <= 1'b0;
            sclk_oe_n_o <= 1'b1;
            mosi_o <= 1'b0;
            data_register <= 8'h00;
            reg_rdata_o <= 8'h00;
        end else begin
            sclk_o <= is_master ? sclk_q : clock_polarity_bit;
            sclk_oe_n_o <= ~is_master;
            mosi_o <= shreg[7];
            if (state == TRAIL && next_state == IDLE) data_register <= {shreg[6:0], rx_next};
            unique case (reg_sel_i)
                SEL_CTL: reg_rdata_o <= {2'b00, mode_fault_flag, 1'b0, busy_o,
                                         slave_selected_flag, master_enable_bit,
                                         interface_enable_bit};
                SEL_DAT: reg_rdata_o <= data_register;
                SEL_CFG: reg_rdata_o <= config_reg;
                SEL_CKR: reg_rdata_o <= clock_rate_register;
            endcase
        end
    end
endmodule : spi_clock_config

/* core/spi_cfg_pkg.sv */
// package of register layout and timing constants for the serial clock/config block
package spi_cfg_pkg;
    // configuration register fields
    localparam int CFG_PHASE_BIT = 7;
    localparam int CFG_POL_BIT = 6;
    localparam int CFG_BC_HI = 5;
    localparam int CFG_BC_LO = 3;
    localparam int CFG_FRS_HI = 2;
    localparam int CFG_FRS_LO = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hc7;
    // control register fields
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_MST_BIT = 1;
    localparam int CTL_SLAVE_SELECTED_FLAG_BIT = 2;
    localparam int CTL_BUSY_BIT = 3;
    localparam int CTL_MODE_FAULT_FLAG_BIT = 5;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CKR_RESET = 8'h00;
    // register selects on the documented special function register port
    localparam logic [1:0] SEL_CTL = 2'h0;
    localparam logic [1:0] SEL_DAT = 2'h1;
    localparam logic [1:0] SEL_CFG = 2'h2;
    localparam logic [1:0] SEL_CKR = 2'h3;
    // serial clock period = HALF_SCALE * (rate + 1) system clocks
    localparam int HALF_SCALE = 2;
    localparam logic [3:0] BITS_MAX = 4'h8;
endpackage : spi_cfg_pkg

/* verif/spi_slave_model.sv */
// slave-side model returning a fixed byte msb first
`timescale 1ns/1ps
// ==========
// model
module spi_slave_model (
    input wire logic sclk_i,
    input wire logic oe_n_i,
    output logic miso_o
);
    logic [7:0] sr = 8'ha5;
    // reload while the clock output is released, shift on trailing edge of mode 0
    always @(negedge sclk_i or posedge oe_n_i) begin
        if (oe_n_i) sr <= 8'ha5;
        else sr <= {sr[6:0], 1'b0};
    end
    // released line shows the inverse, never a held bit
    assign miso_o = oe_n_i ? ~sr[7] : sr[7];
endmodule : spi_slave_model

/* verif/spi_clock_config_assertions.sv */
// checker of serial clock timing and configuration behaviour
`timescale 1ns/1ps
// ==========
// checks
module spi_clock_config_assertions
    import spi_cfg_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic [1:0] reg_sel_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic sclk_o,
    input wire logic sclk_oe_n_o,
    input wire logic slave_select_n_i,
    input wire logic sample_o,
    input wire logic shift_o,
    input wire logic busy_o
);
    logic [7:0] cfg, rate, tog, cnt;
    logic mst, seen, ps, pb;
    wire chg = sclk_o != ps;
    wire [7:0] bits = (cfg[2:0] == 3'h0) ? 8'h08 : {5'h0, cfg[2:0]};
    wire wcfg = reg_wr_i && reg_sel_i == SEL_CFG;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg <= CFG_RESET;
            rate <= CKR_RESET;
            mst <= 1'b0;
            {seen, ps, pb, tog, cnt} <= '0;
        end else begin
            if (wcfg) cfg <= reg_wdata_i;
            if (reg_wr_i && reg_sel_i == SEL_CKR) rate <= reg_wdata_i;
            if (reg_wr_i && reg_sel_i == SEL_CTL) mst <= reg_wdata_i[CTL_MST_BIT];
            ps <= sclk_o;
            pb <= busy_o;
            seen <= busy_o && (seen || chg);
            cnt <= chg ? 8'h00 : cnt + 8'h01;
            tog <= (busy_o && !pb) ? {7'h0, chg} : tog + {7'h0, chg};
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence ss_low;
        !slave_select_n_i [*5];
    endsequence
    a_idle_clk_level: assert property (!busy_o && !pb && $stable(cfg) |-> sclk_o == cfg[CFG_POL_BIT])
        else $error("idle clock level wrong");
    a_half_period_rate: assert property (seen && chg && busy_o |-> cnt == rate)
        else $error("half period does not match rate");
    a_frame_edge_count: assert property (pb && !busy_o |-> ##[0:3] tog == 2 * bits)
        else $error("edge count does not match frame size");
    a_slave_no_clock: assert property (!mst && $past(!mst) |-> sclk_oe_n_o)
        else $error("clock driven in slave mode");
    a_fault_release: assert property (ss_low |-> sclk_oe_n_o && !busy_o)
        else $error("master kept bus under select");
    a_cfg_read_back: assert property ($past(reg_sel_i) == SEL_CFG && !$past(reg_wr_i)
        |-> (reg_rdata_o & CFG_WRITE_MASK) == (cfg & CFG_WRITE_MASK))
        else $error("config read back wrong");
    a_pulse_exclusive: assert property (!(sample_o && shift_o))
        else $error("latch and change edges together");
    a_busy_drives: assert property (busy_o && $past(busy_o) |-> !sclk_oe_n_o)
        else $error("transfer without driven clock");
endmodule : spi_clock_config_assertions
bind spi_clock_config spi_clock_config_assertions chk (.sys_clk_i, .resetn_i, .reg_wr_i,
    .reg_sel_i, .reg_wdata_i, .reg_rdata_o, .sclk_o, .sclk_oe_n_o, .slave_select_n_i,
    .sample_o, .shift_o, .busy_o);

/* verif/testbench.sv */
// register-level bench of the serial clock and configuration block
`timescale 1ns/1ps
// ==========
// bench
module testbench;
    import spi_cfg_pkg::*;
    logic sys_clk_i = 0, resetn_i = 0, reg_wr_i = 0, sclk_i = 0, slave_select_n_i = 1;
    logic [1:0] reg_sel_i = 2'h0;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, d;
    logic sclk_o, sclk_oe_n_o, mosi_o, miso_i, sample_o, shift_o, busy_o;
    int error_cnt = 0, check_count = 0, cyc = 0;
    int n_smp = 0, n_sft = 0, s0 = 0, f0 = 0;
    logic [7:0] mo = 8'h00;
    spi_clock_config dut (.sys_clk_i, .resetn_i, .reg_wr_i, .reg_sel_i, .reg_wdata_i,
        .reg_rdata_o, .sclk_i, .sclk_o, .sclk_oe_n_o, .slave_select_n_i, .mosi_o, .miso_i,
        .sample_o, .shift_o, .busy_o);
    spi_slave_model slave (.sclk_i(sclk_o), .oe_n_i(sclk_oe_n_o), .miso_o(miso_i));
    initial forever #10 sys_clk_i = ~sys_clk_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] s, input logic [7:0] v);
        @(posedge sys_clk_i) #1;
        {reg_wr_i, reg_sel_i, reg_wdata_i} = {1'b1, s, v};
        @(posedge sys_clk_i) #1;
        reg_wr_i = 0;
    endtask : wr
    task automatic rd(input logic [1:0] s);
        @(posedge sys_clk_i) #1;
        reg_sel_i = s;
        repeat (2) @(posedge sys_clk_i);
        #1 d = reg_rdata_o;
    endtask : rd
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    // strobes counted mid-cycle, where they have settled
    always @(negedge sys_clk_i) begin
        if (sample_o === 1'b1) begin
            n_smp++;
            mo = {mo[6:0], mosi_o};
        end
        if (shift_o === 1'b1) n_sft++;
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        #1 resetn_i = 1;
        repeat (3) @(posedge sys_clk_i);
        rd(SEL_CFG);
        chk(d, CFG_RESET);
        rd(SEL_CTL);
        chk(d, CTL_RESET);
        rd(SEL_CKR);
        chk(d, CKR_RESET);
        // four modes, frames 8,1,2,3, rates 3 down to 0
        for (int m = 0; m < 4; m++) begin
            wr(SEL_CTL, 8'h00);
            wr(SEL_CFG, {m[1:0], 3'h0, m[2:0]});
            wr(SEL_CKR, 8'(3 - m));
            rd(SEL_CTL);
            chk(d & 8'h04, 8'h00);
            wr(SEL_CTL, 8'h03);
            s0 = n_smp;
            f0 = n_sft;
            wr(SEL_DAT, 8'h3c);
            @(posedge sys_clk_i) #1;
            chk(busy_o, 1'b1);
            for (int i = 0; i < 300 && busy_o !== 1'b0; i++) @(posedge sys_clk_i) #1;
            chk(busy_o, 1'b0);
            repeat (2) @(posedge sys_clk_i);
            #1 chk(sclk_o, m[0]);
            chk(8'(n_smp - s0), (m == 0) ? 8'h08 : 8'(m));
            chk(8'(n_sft - f0), (m == 0) ? 8'h08 : 8'(m));
            if (m == 0) begin
                chk(mo, 8'h3c);
                rd(SEL_DAT);
                chk(d, 8'ha5);
            end
        end
        wr(SEL_CTL, 8'h03);
        slave_select_n_i = 0;
        repeat (8) @(posedge sys_clk_i);
        #1 slave_select_n_i = 1;
        rd(SEL_CTL);
        chk(d & 8'h23, 8'h20);
        // slave: outside clock at 160 ns, rate register ignored
        wr(SEL_CTL, 8'h01);
        slave_select_n_i = 0;
        s0 = n_smp;
        f0 = n_sft;
        repeat (16) #80 sclk_i = ~sclk_i;
        chk(sclk_oe_n_o, 1'b1);
        wr(SEL_DAT, 8'h55);
        @(posedge sys_clk_i) #1;
        chk(busy_o, 1'b0);
        chk(8'(n_smp - s0), 8'h08);
        chk(8'(n_sft - f0), 8'h08);
        rd(SEL_CTL);
        chk(d & 8'h04, 8'h04);
        slave_select_n_i = 1;
        conclude();
    end
endmodule : testbench
